// ===== shared/hvm_pkg.sv
// Constants and carriers of the high voltage monitor block
// How it works
// RULE1: Monitor is 8-bit read-only, resets 0x00
// RULE2: Reached only via command and data registers
// RULE3: Bits show live state unless marked latched
// RULE4: Bit 7 follows wake pin in input mode
// RULE5: Bit 6 shows thermal shutdown event
// RULE6: Bit 5 follows test-interface pin when enabled
// RULE7: Bit 4 shows voltage channel buffer enable
// RULE8: Bit 3 shows supply stayed above 2.1V
// RULE9: Bit 3 set again only by re-enabling flag
// RULE10: Bit 2 bus driver short, re-enable clears
// RULE11: Bit 1 test driver short, re-enable clears
// RULE12: Bit 0 shows wake driver short circuit; code latches it until re-enable clears
// RULE13: Driver re-enable bit clears itself after write
// RULE14: Host sets wake mode bit for readback
// RULE15: Busy held 10us per transfer, host waits
// RULE16: Monitor read captured whole in one cycle
package hvm_pkg;

   // Indirect register indices behind the command register
   localparam logic [3:0] IDX_CONFIG_FIRST  = 4'h0;
   localparam logic [3:0] IDX_CONFIG_SECOND = 4'h1;
   localparam logic [3:0] IDX_MONITOR       = 4'h2;

   // Reset values
   localparam logic [7:0] MONITOR_RESET = 8'h00;
   localparam logic [7:0] CONFIG_RESET  = 8'h00;

   // Monitor bit positions
   localparam int MON_WAKE_PIN  = 7;
   localparam int MON_OVERTEMP  = 6;
   localparam int MON_TEST_PIN  = 5;
   localparam int MON_BUF_EN    = 4;
   localparam int MON_LVF       = 3;
   localparam int MON_BUS_SHORT = 2;
   localparam int MON_TEST_SHRT = 1;
   localparam int MON_WAKE_SHRT = 0;

   // Configuration bit positions
   localparam int CFG1_LVF_EN    = 2;
   localparam int CFG2_WAKE_MODE = 4;
   localparam int CFG2_REENABLE  = 3;

   // Transfer timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int BUSY_TIME_NS  = 10000;
   localparam int BUSY_CYCLES   = BUSY_TIME_NS / CLK_PERIOD_NS;
   localparam int BUSY_W        = 8;

   // Pin and analog inputs, all asynchronous to clk_i
   typedef struct packed {
      logic wake_pin;
      logic test_interface_pin;
      logic thermal_shutdown;
      logic buffer_enabled;
      logic supply_ok;
      logic bus_short;
      logic test_short;
      logic wake_short;
   } hvm_pins_t;

   // Command written into the interface command register
   typedef struct packed {
      logic       write;
      logic [3:0] index;
      logic [7:0] wdata;
   } hvm_cmd_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_BUSY = 2'b10
   } hvm_state_t;

endpackage : hvm_pkg

// ===== rtl/hvm_monitor.sv
// High voltage monitor register with its indirect command interface
`timescale 1ns/1ps
`default_nettype none
module hvm_monitor (
   // Clock and reset
   input  wire logic            clk_i,
   input  wire logic            rst_i,
   // Command register write port
   input  wire logic            cmd_valid_i,
   input  wire hvm_pkg::hvm_cmd_t cmd_i,
   // Command status and data register
   output logic                 busy_o,
   output logic                 error_o,
   output logic [7:0]           data_o,
   // High voltage circuits
   input  wire hvm_pkg::hvm_pins_t pins_i,
   output logic                 wake_mode_o,
   output logic                 driver_reenable_o
);
   import hvm_pkg::*;

   localparam logic [BUSY_W-1:0] BUSY_LAST =
      BUSY_W'(BUSY_CYCLES - 1);

   typedef struct packed {
      hvm_state_t        state;
      logic [BUSY_W-1:0] count;
      hvm_cmd_t          cmd;
      logic              error;
      logic [7:0]        data;
      logic [7:0]        config_first;
      logic [7:0]        config_second;
      logic [7:0]        sync1;
      logic [7:0]        sync2;
      logic [7:0]        sync3;
      logic [7:0]        filt;
      logic              low_voltage_flag;
      logic              bus_short;
      logic              test_short;
      logic              wake_short;
      logic              reenable;
   } hvm_regs_t;

   hvm_regs_t r;
   hvm_regs_t next_r;

   hvm_pins_t  live;
   logic [7:0] monitor;
   logic       do_apply;
   logic       lvf_arm;
   logic       reenable_write;

   // Filtered pin view
   assign live = hvm_pins_t'(r.filt);

   // Live monitor value
   always_comb begin
      monitor                = MONITOR_RESET;
      monitor[MON_WAKE_PIN]  = r.config_second[CFG2_WAKE_MODE] &
                               live.wake_pin;                   // [RULE4]
      monitor[MON_OVERTEMP]  = live.thermal_shutdown;           // [RULE5]
      // Readback of both pins shares the wake mode enable
      monitor[MON_TEST_PIN]  = r.config_second[CFG2_WAKE_MODE] &
                               live.test_interface_pin;         // [RULE6]
      monitor[MON_BUF_EN]    = live.buffer_enabled;             // [RULE7] [RULE3]
      monitor[MON_LVF]       = r.config_first[CFG1_LVF_EN] &
                               r.low_voltage_flag;                           // [RULE8]
      monitor[MON_BUS_SHORT] = r.bus_short;                     // [RULE10]
      monitor[MON_TEST_SHRT] = r.test_short;                    // [RULE11]
      monitor[MON_WAKE_SHRT] = r.wake_short;                    // [RULE12]
   end

   always_comb begin
      next_r         = r;
      do_apply       = 1'b0;
      lvf_arm        = 1'b0;
      reenable_write = 1'b0;

      // Three-stage synchroniser; accept value once stages 2 and 3 agree
      next_r.sync1 = pins_i;
      next_r.sync2 = r.sync1;
      next_r.sync3 = r.sync2;
      for (int i = 0; i < 8; i++) begin
         if (r.sync2[i] == r.sync3[i]) begin
            next_r.filt[i] = r.sync3[i];
         end
      end

      case (r.state)
         ST_IDLE: begin
            // Commands while busy never reach here, so they are dropped
            if (cmd_valid_i) begin
               next_r.state = ST_BUSY;
               next_r.count = '0;
               next_r.cmd   = cmd_i;
               next_r.error = 1'b0;
               if (!cmd_i.write) begin
                  // Whole byte captured in one cycle, order kept
                  case (cmd_i.index)
                     IDX_MONITOR:       next_r.data = monitor;  // [RULE16] [RULE2]
                     IDX_CONFIG_FIRST:  next_r.data = r.config_first;
                     IDX_CONFIG_SECOND: next_r.data = r.config_second;
                     default: begin
                        next_r.data  = 8'h00;
                        next_r.error = 1'b1;
                     end
                  endcase
               end else if (cmd_i.index != IDX_CONFIG_FIRST &&
                            cmd_i.index != IDX_CONFIG_SECOND) begin
                  // Monitor is read-only; a write only flags an error
                  next_r.error = 1'b1;                           // [RULE1]
               end
            end
         end
         ST_BUSY: begin
            if (r.count == BUSY_LAST) begin
               next_r.state = ST_IDLE;                           // [RULE15]
               do_apply     = r.cmd.write;
            end else begin
               next_r.count = r.count + 1'b1;                    // [RULE15]
            end
         end
         default: begin
            next_r.state = ST_IDLE;
         end
      endcase

      // Writes land at the end of the serial latency
      if (do_apply) begin
         case (r.cmd.index)
            IDX_CONFIG_FIRST: begin
               next_r.config_first = r.cmd.wdata;
               lvf_arm = r.cmd.wdata[CFG1_LVF_EN];
            end
            IDX_CONFIG_SECOND: begin
               next_r.config_second = r.cmd.wdata;
               reenable_write = r.cmd.wdata[CFG2_REENABLE];
            end
            default: begin
               next_r.error = r.error;
            end
         endcase
      end

      // Re-enable bit stored for exactly one cycle
      if (r.config_second[CFG2_REENABLE] && !reenable_write) begin
         next_r.config_second[CFG2_REENABLE] = 1'b0;             // [RULE13]
      end
      next_r.reenable = reenable_write;

      // Low voltage flag: re-arming samples the supply afresh
      if (lvf_arm) begin
         next_r.low_voltage_flag = live.supply_ok;                            // [RULE9]
      end else if (r.config_first[CFG1_LVF_EN] && !live.supply_ok) begin
         next_r.low_voltage_flag = 1'b0;                                      // [RULE8]
      end

      // Short flags: the re-enable clears, a live short wins
      if (reenable_write) begin
         next_r.bus_short  = 1'b0;
         next_r.test_short = 1'b0;
         next_r.wake_short = 1'b0;
      end
      if (live.bus_short) begin
         next_r.bus_short = 1'b1;                                // [RULE10]
      end
      if (live.test_short) begin
         next_r.test_short = 1'b1;                               // [RULE11]
      end
      if (live.wake_short) begin
         next_r.wake_short = 1'b1;                               // [RULE12]
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r.state         <= ST_IDLE;
         r.count         <= '0;
         r.cmd           <= '0;
         r.error         <= 1'b0;
         r.data          <= MONITOR_RESET;                       // [RULE1]
         r.config_first  <= CONFIG_RESET;
         r.config_second <= CONFIG_RESET;
         r.sync1         <= '0;
         r.sync2         <= '0;
         r.sync3         <= '0;
         r.filt          <= '0;
         r.low_voltage_flag           <= 1'b0;
         r.bus_short     <= 1'b0;
         r.test_short    <= 1'b0;
         r.wake_short    <= 1'b0;
         r.reenable      <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   assign busy_o            = r.state == ST_BUSY;
   assign error_o           = r.error;
   assign data_o            = r.data;
   assign wake_mode_o       = r.config_second[CFG2_WAKE_MODE];
   assign driver_reenable_o = r.reenable;

endmodule : hvm_monitor
`default_nettype wire

// ===== tb/hvm_monitor_props.sv
// Port-level checks of the monitor block
`timescale 1ns/1ps
`default_nettype none
module hvm_monitor_props (
   // Clock, reset and command port
   input wire logic              clk_i,
   input wire logic              rst_i,
   input wire logic              cmd_valid_i,
   input wire hvm_pkg::hvm_cmd_t  cmd_i,
   // Outputs and pins
   input wire logic              busy_o,
   input wire logic              error_o,
   input wire logic [7:0]        data_o,
   input wire hvm_pkg::hvm_pins_t pins_i,
   input wire logic              wake_mode_o,
   input wire logic              driver_reenable_o
);
   import hvm_pkg::*;
   logic [3:0] quiet;
   logic [7:0] prev;
   wire        take = cmd_valid_i && !busy_o;
   // Pins quiet long enough to pass the input synchroniser
   wire        rd = take && !cmd_i.write && cmd_i.index == IDX_MONITOR
                    && quiet > 4'h8;
   always_ff @(posedge clk_i) begin
      prev <= pins_i;
      if (rst_i || pins_i != prev) quiet <= 4'h0;
      else if (quiet != 4'hf) quiet <= quiet + 4'h1;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_reset_clear: assert property (disable iff (1'b0) rst_i |=>
      !busy_o && !error_o && data_o == MONITOR_RESET && !wake_mode_o
      && !driver_reenable_o) else $error("reset state wrong");
   a_busy_window: assert property (take |=>
      busy_o [*8] ##92 busy_o ##1 !busy_o) else $error("busy length");
   a_data_hold: assert property (busy_o && $past(busy_o) |->
      $stable(data_o) && $stable(error_o)) else $error("data moved");
   a_live_bits: assert property (rd |=>
      data_o[MON_OVERTEMP] == $past(pins_i.thermal_shutdown)
      && data_o[MON_BUF_EN] == $past(pins_i.buffer_enabled))
      else $error("live bit wrong");
   a_pin_readback: assert property (rd |=>
      data_o[7] == ($past(pins_i.wake_pin) & $past(wake_mode_o))
      && data_o[5] == ($past(pins_i.test_interface_pin) & $past(wake_mode_o)))
      else $error("readback wrong");
   a_bad_index: assert property (take && (cmd_i.index > IDX_MONITOR
      || cmd_i.write && cmd_i.index == IDX_MONITOR) |=> error_o)
      else $error("no error flag");
   a_good_read: assert property (take && !cmd_i.write
      && cmd_i.index <= IDX_MONITOR |=> !error_o) else $error("false error");
   a_reenable_once: assert property (driver_reenable_o |->
      $fell(busy_o) ##1 !driver_reenable_o) else $error("reenable pulse");
   a_mode_at_end: assert property ($changed(wake_mode_o) |->
      $fell(busy_o)) else $error("mode changed early");
endmodule : hvm_monitor_props
bind hvm_monitor hvm_monitor_props hvm_monitor_props_i (.clk_i, .rst_i,
   .cmd_valid_i, .cmd_i, .busy_o, .error_o, .data_o, .pins_i, .wake_mode_o,
   .driver_reenable_o);
`default_nettype wire

// ===== tb/hvm_host_model.sv
// Host model giving indirect commands to the monitor block
`timescale 1ns/1ps
`default_nettype none
module hvm_host_model (
   // Clock and status
   input  wire logic       clk_i,
   input  wire logic       busy_i,
   // Command register write port
   output logic            cmd_valid_o,
   output hvm_pkg::hvm_cmd_t cmd_o
);
   import hvm_pkg::*;
   initial begin
      cmd_valid_o = 1'b0;
      cmd_o = '0;
   end
   task automatic xfer(input logic w, input logic [3:0] idx,
                       input logic [7:0] wd, output logic ok);
      int n;
      n = 0;
      @(negedge clk_i);
      cmd_o = '{write: w, index: idx, wdata: wd};
      cmd_valid_o = 1'b1;
      @(negedge clk_i);
      cmd_valid_o = 1'b0;
      // Released lines show junk, not the old command
      cmd_o = ~cmd_o;
      @(negedge clk_i);
      while (busy_i && n < 200) begin
         @(negedge clk_i);
         n++;
      end
      ok = n > 90 && n < 200;
   endtask : xfer
endmodule : hvm_host_model
`default_nettype wire

// ===== tb/hvm_monitor_tb.sv
// Self-checking bench of the monitor block
`timescale 1ns/1ps
`default_nettype none
module hvm_monitor_tb;
   import hvm_pkg::*;
   logic       clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic       cmd_valid_i, busy_o, error_o, wake_mode_o, driver_reenable_o;
   logic       ok, low_voltage_flag;
   hvm_cmd_t   cmd_i;
   hvm_pins_t  pins_i = '0;
   logic [7:0] data_o, cfg1, cfg2;
   logic [2:0] flags;
   logic [15:0] rnd = 16'h6ea6;
   int         n_fail = 0, samples_checked = 0, cyc = 0;
   always #50 clk_i = ~clk_i;
   hvm_monitor hvm_monitor_i (.clk_i, .rst_i, .cmd_valid_i, .cmd_i, .busy_o,
      .error_o, .data_o, .pins_i, .wake_mode_o, .driver_reenable_o);
   hvm_host_model hvm_host_model_i (.clk_i, .busy_i(busy_o),
      .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i));
   function automatic logic [15:0] lfsr(logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : lfsr
   function automatic logic [7:0] exp_mon(hvm_pins_t p);
      return {p.wake_pin & cfg2[4], p.thermal_shutdown,
              p.test_interface_pin & cfg2[4], p.buffer_enabled,
              low_voltage_flag & cfg1[2], flags};
   endfunction : exp_mon
   task automatic chk(logic [7:0] got, logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic cmd(logic w, logic [3:0] idx, logic [7:0] wd);
      hvm_host_model_i.xfer(w, idx, wd, ok);
      chk({7'h0, ok}, 8'h01);
   endtask : cmd
   task automatic set_pins(hvm_pins_t p);
      pins_i = p;
      flags |= {p.bus_short, p.test_short, p.wake_short};
      if (cfg1[2] && !p.supply_ok) low_voltage_flag = 1'b0;
      repeat (6) @(negedge clk_i);
   endtask : set_pins
   task automatic rd_mon();
      cmd(1'b0, IDX_MONITOR, 8'h00);
      chk(data_o, exp_mon(pins_i));
      chk({7'h0, error_o}, 8'h00);
   endtask : rd_mon
   task automatic wr(logic [3:0] idx, logic [7:0] v);
      cmd(1'b1, idx, v);
      if (idx == IDX_CONFIG_FIRST) begin
         cfg1 = v;
         if (v[2]) low_voltage_flag = pins_i.supply_ok;
      end else begin
         cfg2 = v & 8'hf7;
         if (v[3]) flags = {pins_i.bus_short, pins_i.test_short,
                            pins_i.wake_short};
      end
   endtask : wr
   task automatic close_out();
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out
   // Ceiling well above the few thousand cycles the run needs
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 30000) begin
         n_fail++;
         close_out();
      end
   end
   initial begin
      {cfg1, cfg2, flags, low_voltage_flag} = '0;
      repeat (2) @(negedge clk_i);
      rst_i = 1'b0;
      rd_mon();
      cmd(1'b1, IDX_MONITOR, 8'hff);
      chk({7'h0, error_o}, 8'h01);
      rd_mon();
      cmd(1'b0, 4'hf, 8'h00);
      chk({7'h0, error_o}, 8'h01);
      set_pins(8'hff);
      set_pins(8'h00);
      rd_mon();
      wr(IDX_CONFIG_SECOND, 8'h18);
      rd_mon();
      cmd(1'b0, IDX_CONFIG_SECOND, 8'h00);
      chk(data_o, cfg2);
      for (int i = 0; i < 16; i++) begin
         rnd = lfsr(rnd);
         set_pins(hvm_pins_t'(rnd[7:0]));
         rd_mon();
         rnd = lfsr(rnd);
         wr(IDX_CONFIG_FIRST, rnd[7:0]);
         wr(IDX_CONFIG_SECOND, rnd[15:8]);
         rd_mon();
      end
      close_out();
   end
endmodule : hvm_monitor_tb
`default_nettype wire
